// ==== rtl/supply_reset_watchdog_supervisor.sv ====
// reset supervisor, watchdog and memory write gating of the serial memory
//
// Behaviour
// - hold both resets from supply trip through the timeout after supply recovers
// - after the timeout, stop driving both reset pins
// - supply dropping below trip level asserts both resets at once
// - an externally forced reset level that begins while running starts and holds our reset condition
// - active-low pin restarts timeout on rise, active-high pin on fall
// - reset pin pulses up to 100 ns never start a reset
// - no data line transition for 1.6 s triggers a reset
// - every data line edge clears the watchdog; host must toggle it
// - watchdog counter held at zero while any reset is active
// - build option removes watchdog resets, keeps supply and manual ones
// - write protect high makes the whole array read only
// - no array writes while the supply is below the trip level
// - while a reset is active, ignore accesses and send no acknowledge
// - program cycle starts at the write stop, ends within 10 ms
// - bus interface disabled during the program cycle
// - noise up to 200 ns on clock and data is not a bus event
`timescale 1ns/1ps
`default_nettype none
module supply_reset_watchdog_supervisor
    import sup_pkg::*;
#(
    parameter int POR_CYC = POR_TIMEOUT_CYCLES,
    parameter int WDOG_CYC = WDOG_PERIOD_CYCLES,
    parameter int PROG_CYC = PROGRAM_CYCLE_CYCLES,
    parameter int RST_FILT_CYC = RESET_PULSE_FILTER_CYCLES,
    parameter int BUS_FILT_CYC = INPUT_NOISE_FILTER_CYCLES,
    parameter bit WATCHDOG_EN = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic supply_ok_i,
    input wire logic write_prot_i,
    input wire logic rst_n_pin_i,
    output logic rst_n_pin_o,
    output logic rst_n_pin_oe_o,
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    input wire logic sda_i,
    input wire logic scl_i,
    input wire logic write_stop_i,
    output logic sda_filt_o,
    output logic scl_filt_o,
    output logic reset_active_o,
    output logic bus_enable_o,
    output logic write_allow_o,
    output logic program_busy_o
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    filter_if rst_n_line ();
    filter_if rst_line ();
    filter_if sda_line ();
    filter_if scl_line ();

    sup_state_t state_r;
    sup_state_t state_nxt;
    logic [CNT_W-1:0] tmo_cnt_r;
    logic [CNT_W-1:0] wdog_cnt_r;
    logic [CNT_W-1:0] prog_cnt_r;
    logic supply_meta_r;
    logic supply_ok_r;
    logic wp_meta_r;
    logic wp_r;
    logic drive_r;
    logic rst_n_val_r;
    logic rst_val_r;
    logic reset_active_r;
    logic bus_enable_r;
    logic write_allow_r;
    logic busy_r;
    logic sda_filt_r;
    logic scl_filt_r;
    logic wdog_expire;
    logic pin_forced;
    logic pin_release;
    logic tmo_done;
    logic resetting;
    logic write_ok;

    // true once a counter has reached its limit
    function automatic logic reached(input logic [CNT_W-1:0] cnt,
                                     input int limit);
        reached = (cnt >= CNT_W'(limit));
    endfunction

    // ----------------------------------------------------------------
    // input conditioning
    // ----------------------------------------------------------------
    assign rst_n_line.raw = rst_n_pin_i;
    assign rst_line.raw = rst_pin_i;
    assign sda_line.raw = sda_i;
    assign scl_line.raw = scl_i;

    // reset pins reject short glitches
    pin_filter #(.STABLE_CYC(RST_FILT_CYC), .INIT(RST_N_PIN_IDLE))
    u_rst_n_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .line(rst_n_line.filter)
    );

    pin_filter #(.STABLE_CYC(RST_FILT_CYC), .INIT(RST_PIN_IDLE))
    u_rst_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .line(rst_line.filter)
    );

    // bus lines suppress noise pulses before anyone sees them
    pin_filter #(.STABLE_CYC(BUS_FILT_CYC), .INIT(SDA_IDLE))
    u_sda_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .line(sda_line.filter)
    );

    pin_filter #(.STABLE_CYC(BUS_FILT_CYC), .INIT(SCL_IDLE))
    u_scl_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .line(scl_line.filter)
    );

    // supply comparator and write protect cross in through two flops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            supply_meta_r <= 1'b0;
            supply_ok_r <= 1'b0;
            wp_meta_r <= 1'b0;
            wp_r <= 1'b0;
        end else begin
            supply_meta_r <= supply_ok_i;
            supply_ok_r <= supply_meta_r;
            wp_meta_r <= write_prot_i;
            wp_r <= wp_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // reset sequencer
    // ----------------------------------------------------------------
    // external active level seen on either pin while released
    assign pin_forced = (rst_n_line.filt == 1'b0) || (rst_line.filt == 1'b1);
    // manual release edges: low pin rising, high pin falling
    assign pin_release = rst_n_line.rise || rst_line.fall;
    assign tmo_done = reached(tmo_cnt_r, POR_CYC - 1);
    assign resetting = (state_r != ST_RUN);

    // next state of the sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_UNDERVOLT: begin
                if (supply_ok_r) begin
                    state_nxt = ST_TIMEOUT;
                end
            end
            ST_TIMEOUT: begin
                if (tmo_done) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_FORCED: begin
                if (pin_release && !pin_forced) begin
                    state_nxt = ST_TIMEOUT;
                end
            end
            ST_RUN: begin
                // onset only: our released drive lingers in the filters
                if (rst_n_line.fall || rst_line.rise) begin
                    state_nxt = ST_FORCED;
                end else if (wdog_expire) begin
                    state_nxt = ST_TIMEOUT;
                end
            end
        endcase
        // a supply trip overrides every other state
        if (!supply_ok_r) begin
            state_nxt = ST_UNDERVOLT;
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_UNDERVOLT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // reset timeout counter, restarted on every entry
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tmo_cnt_r <= CNT_ZERO;
        end else if (state_r != ST_TIMEOUT || state_nxt != ST_TIMEOUT) begin
            tmo_cnt_r <= CNT_ZERO;
        end else begin
            tmo_cnt_r <= tmo_cnt_r + CNT_ONE;
        end
    end

    // ----------------------------------------------------------------
    // watchdog
    // ----------------------------------------------------------------
    // expiry only exists when the watchdog is built
    assign wdog_expire = WATCHDOG_EN && reached(wdog_cnt_r, WDOG_CYC);

    // counts idle time on the data line
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wdog_cnt_r <= CNT_ZERO;
        end else if (!WATCHDOG_EN || resetting) begin
            wdog_cnt_r <= CNT_ZERO;
        end else if (sda_line.rise || sda_line.fall) begin
            wdog_cnt_r <= CNT_ZERO;
        end else if (!wdog_expire) begin
            wdog_cnt_r <= wdog_cnt_r + CNT_ONE;
        end
    end

    // ----------------------------------------------------------------
    // memory write gating and program cycle
    // ----------------------------------------------------------------
    // writes need no protect, good supply and no reset
    assign write_ok = !wp_r && supply_ok_r && !resetting;

    // program cycle timer started by the stop ending a write
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
            prog_cnt_r <= CNT_ZERO;
        end else if (busy_r) begin
            if (reached(prog_cnt_r, PROG_CYC - 1)) begin
                busy_r <= 1'b0;
                prog_cnt_r <= CNT_ZERO;
            end else begin
                prog_cnt_r <= prog_cnt_r + CNT_ONE;
            end
        end else if (write_stop_i && write_ok && bus_enable_r) begin
            busy_r <= 1'b1;
            prog_cnt_r <= CNT_ZERO;
        end
    end

    // registered permissions for the serial slave
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reset_active_r <= 1'b1;
            bus_enable_r <= 1'b0;
            write_allow_r <= 1'b0;
        end else begin
            reset_active_r <= resetting;
            // no answers while reset or programming
            bus_enable_r <= !resetting && !busy_r;
            write_allow_r <= write_ok && !busy_r;
        end
    end

    // filtered bus lines handed on to the slave
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_filt_r <= SDA_IDLE;
            scl_filt_r <= SCL_IDLE;
        end else begin
            sda_filt_r <= sda_line.filt;
            scl_filt_r <= scl_line.filt;
        end
    end

    // ----------------------------------------------------------------
    // reset pin drivers
    // ----------------------------------------------------------------
    // both pins driven in undervolt and timeout; released otherwise
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            drive_r <= 1'b1;
            rst_n_val_r <= 1'b0;
            rst_val_r <= 1'b1;
        end else begin
            // forced state leaves the pins to the external source
            drive_r <= (state_nxt == ST_UNDERVOLT) ||
                       (state_nxt == ST_TIMEOUT);
            rst_n_val_r <= 1'b0;
            rst_val_r <= 1'b1;
        end
    end

    assign rst_n_pin_o = rst_n_val_r;
    assign rst_n_pin_oe_o = ~drive_r; // low while driving
    assign rst_pin_o = rst_val_r;
    assign rst_pin_oe_o = ~drive_r; // low while driving
    assign reset_active_o = reset_active_r;
    assign bus_enable_o = bus_enable_r;
    assign write_allow_o = write_allow_r;
    assign program_busy_o = busy_r;
    assign sda_filt_o = sda_filt_r;
    assign scl_filt_o = scl_filt_r;

endmodule
`default_nettype wire

// ==== common/sup_pkg.sv ====
// constants and types shared by the supervisor and its input filters
package sup_pkg;

    // ----------------------------------------------------------------
    // clock
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;

    // ----------------------------------------------------------------
    // times in their own units, and the cycle counts derived from them
    // ----------------------------------------------------------------
    // reset timeout after supply trip or manual or watchdog reset
    localparam int POR_TIMEOUT_MIN_MS = 130;
    localparam int POR_TIMEOUT_MS = 200;
    localparam int POR_TIMEOUT_MAX_MS = 270;
    localparam int POR_TIMEOUT_CYCLES =
        (POR_TIMEOUT_MS * 1_000_000) / CLK_PERIOD_NS;
    // watchdog period on the serial data line
    localparam real WDOG_PERIOD_S = 1.6;
    localparam int WDOG_PERIOD_CYCLES =
        int'(WDOG_PERIOD_S * 1.0e9 / CLK_PERIOD_NS);
    // longest internal program cycle, rounded down
    localparam int PROGRAM_CYCLE_TIME_MS = 10;
    localparam int PROGRAM_CYCLE_CYCLES =
        (PROGRAM_CYCLE_TIME_MS * 1_000_000) / CLK_PERIOD_NS;
    // glitch width rejected on the reset pins, rounded up
    localparam int RESET_PULSE_FILTER_WIDTH_NS = 100;
    localparam int RESET_PULSE_FILTER_CYCLES =
        (RESET_PULSE_FILTER_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // noise width suppressed on the serial clock and data, rounded up
    localparam int INPUT_NOISE_FILTER_NS = 200;
    localparam int INPUT_NOISE_FILTER_CYCLES =
        (INPUT_NOISE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // widths and values after reset
    // ----------------------------------------------------------------
    localparam int CNT_W = 32;
    localparam int FILT_CNT_W = 8;
    localparam logic RST_N_PIN_IDLE = 1'b1;
    localparam logic RST_PIN_IDLE = 1'b0;
    localparam logic SDA_IDLE = 1'b1;
    localparam logic SCL_IDLE = 1'b1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

    // ----------------------------------------------------------------
    // supervisor states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_UNDERVOLT,
        ST_TIMEOUT,
        ST_FORCED,
        ST_RUN
    } sup_state_t;

endpackage

// ==== common/filter_if.sv ====
// filtered input line between a pin filter and the supervisor
`timescale 1ns/1ps
`default_nettype none
interface filter_if;
    logic raw;
    logic filt;
    logic rise;
    logic fall;
    modport filter (input raw, output filt, output rise, output fall);
    modport user (output raw, input filt, input rise, input fall);
endinterface
`default_nettype wire

// ==== rtl/pin_filter.sv ====
// two-flop synchroniser and stability filter for one pin
`timescale 1ns/1ps
`default_nettype none
module pin_filter
    import sup_pkg::*;
#(
    parameter int STABLE_CYC = 2,
    parameter logic INIT = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    filter_if.filter line
);

    logic meta_r;
    logic sync_r;
    logic filt_r;
    logic rise_r;
    logic fall_r;
    logic [FILT_CNT_W-1:0] cnt_r;

    // ----------------------------------------------------------------
    // synchroniser
    // ----------------------------------------------------------------
    // first stage is read only by the second stage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= INIT;
            sync_r <= INIT;
        end else begin
            meta_r <= line.raw;
            sync_r <= meta_r;
        end
    end

    // ----------------------------------------------------------------
    // stability filter
    // ----------------------------------------------------------------
    // a new level is taken after STABLE_CYC+1 differing samples
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            filt_r <= INIT;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end else begin
            rise_r <= 1'b0;
            fall_r <= 1'b0;
            if (sync_r == filt_r) begin
                cnt_r <= '0;
            end else if (cnt_r == FILT_CNT_W'(STABLE_CYC)) begin
                cnt_r <= '0;
                filt_r <= sync_r;
                rise_r <= sync_r;
                fall_r <= ~sync_r;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign line.filt = filt_r;
    assign line.rise = rise_r;
    assign line.fall = fall_r;

endmodule
`default_nettype wire

// ==== test/supervisor_monitor.sv ====
// concurrent checks on the supervisor ports
`timescale 1ns/1ps
`default_nettype none
module supervisor_monitor
    import sup_pkg::*;
#(
    parameter int POR_CYC = 50,
    parameter int WDOG_CYC = 200,
    parameter int PROG_CYC = 30,
    parameter bit WATCHDOG_EN = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic supply_ok_i,
    input wire logic write_prot_i,
    input wire logic write_stop_i,
    input wire logic rst_n_pin_o,
    input wire logic rst_n_pin_oe_o,
    input wire logic rst_pin_o,
    input wire logic rst_pin_oe_o,
    input wire logic sda_filt_o,
    input wire logic reset_active_o,
    input wire logic bus_enable_o,
    input wire logic write_allow_o,
    input wire logic program_busy_o
);
    logic sda_q_r;
    logic [CNT_W-1:0] idle_r;
    logic [CNT_W-1:0] busy_r;
    logic [CNT_W-1:0] drive_r;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    // quiet cycles on the data line outside reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_q_r <= SDA_IDLE;
            idle_r <= CNT_ZERO;
        end else begin
            sda_q_r <= sda_filt_o;
            idle_r <= (reset_active_o || sda_filt_o != sda_q_r) ?
                CNT_ZERO : idle_r + CNT_ONE;
        end
    end
    // lengths of the program cycle and of our own pin drive
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_r <= CNT_ZERO;
            drive_r <= CNT_ZERO;
        end else begin
            busy_r <= program_busy_o ? busy_r + CNT_ONE : CNT_ZERO;
            drive_r <= rst_n_pin_oe_o ? CNT_ZERO : drive_r + CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_OE_PAIR: assert property (rst_n_pin_oe_o == rst_pin_oe_o)
        else $error("reset pin enables differ");
    AST_DRIVE_LEVEL: assert property (
        !rst_n_pin_oe_o |-> !rst_n_pin_o && rst_pin_o)
        else $error("reset pins driven to wrong levels");
    AST_SUPPLY_TRIP: assert property (
        $fell(supply_ok_i) |-> ##[1:6] (!rst_n_pin_oe_o && reset_active_o))
        else $error("supply trip did not assert reset");
    AST_TIMEOUT_LEN: assert property (
        $rose(rst_n_pin_oe_o) |-> drive_r >= CNT_W'(POR_CYC - 1))
        else $error("reset drive released too early");
    AST_RESET_GATES: assert property (
        reset_active_o && $past(reset_active_o) |->
            !bus_enable_o && !write_allow_o)
        else $error("bus or writes enabled during reset");
    AST_SUPPLY_LOCK: assert property (
        !supply_ok_i [*5] |-> !write_allow_o)
        else $error("writes allowed with supply low");
    AST_WP_LOCK: assert property (write_prot_i [*5] |-> !write_allow_o)
        else $error("writes allowed while protected");
    AST_PROG_CAUSE: assert property (
        $rose(program_busy_o) |-> $past(write_stop_i) && $past(bus_enable_o))
        else $error("program cycle without write stop");
    AST_PROG_LEN: assert property (
        $fell(program_busy_o) |-> busy_r == CNT_W'(PROG_CYC))
        else $error("program cycle length wrong");
    AST_PROG_BUS: assert property (
        program_busy_o && $past(program_busy_o) |->
            !bus_enable_o && !write_allow_o)
        else $error("bus enabled during program cycle");
    AST_WDOG_FIRE: assert property (
        WATCHDOG_EN && idle_r > CNT_W'(WDOG_CYC) |-> reset_active_o)
        else $error("watchdog did not fire");
endmodule

bind supply_reset_watchdog_supervisor supervisor_monitor #(
    .POR_CYC(POR_CYC), .WDOG_CYC(WDOG_CYC), .PROG_CYC(PROG_CYC),
    .WATCHDOG_EN(WATCHDOG_EN)) u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .supply_ok_i(supply_ok_i),
    .write_prot_i(write_prot_i), .write_stop_i(write_stop_i),
    .rst_n_pin_o(rst_n_pin_o), .rst_n_pin_oe_o(rst_n_pin_oe_o),
    .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
    .sda_filt_o(sda_filt_o), .reset_active_o(reset_active_o),
    .bus_enable_o(bus_enable_o), .write_allow_o(write_allow_o),
    .program_busy_o(program_busy_o));
`default_nettype wire

// ==== test/host_net_model.sv ====
// host side: reset net with pulls, push buttons and bus activity
`timescale 1ns/1ps
`default_nettype none
module host_net_model
    import sup_pkg::*;
(
    input wire logic rst_n_pin_o,
    input wire logic rst_n_pin_oe_o,
    input wire logic rst_pin_o,
    input wire logic rst_pin_oe_o,
    input wire logic push_low_i,
    input wire logic push_high_i,
    input wire logic frame_i,
    output logic rst_n_lvl_o,
    output logic rst_lvl_o,
    output logic sda_o,
    output logic scl_o
);
    // wired net: pull-up on the active-low pin, pull-down on the other
    assign rst_n_lvl_o = !((!rst_n_pin_oe_o && !rst_n_pin_o) || push_low_i);
    assign rst_lvl_o = (!rst_pin_oe_o && rst_pin_o) || push_high_i;
    // link clock runs only in frames; data flips while clock is low
    initial begin
        scl_o = SCL_IDLE;
        sda_o = SDA_IDLE;
        #7;
        forever begin
            #200;
            if (frame_i) begin
                scl_o = !scl_o;
                if (!scl_o) sda_o = !sda_o;
            end else begin
                scl_o = SCL_IDLE;
                sda_o = SDA_IDLE;
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/supply_reset_watchdog_supervisor_tb_top.sv ====
// self-checking bench for the reset supervisor
`timescale 1ns/1ps
`default_nettype none
module supply_reset_watchdog_supervisor_tb_top;
    import sup_pkg::*;
    localparam int POR = 50;
    localparam int WDOG = 200;
    localparam int PROG = 30;
    logic clk_i, rst_i, supply_ok, write_prot, write_stop;
    logic push_low, push_high, frame, sda, scl, rn_lvl, r_lvl;
    logic rn_o, rn_oe, r_o, r_oe, ra, ra2, bus_en, wr_ok, busy;
    int fails, n_checks, n;

    supply_reset_watchdog_supervisor #(.POR_CYC(POR), .WDOG_CYC(WDOG),
        .PROG_CYC(PROG)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .supply_ok_i(supply_ok),
        .write_prot_i(write_prot), .rst_n_pin_i(rn_lvl), .rst_n_pin_o(rn_o),
        .rst_n_pin_oe_o(rn_oe), .rst_pin_i(r_lvl), .rst_pin_o(r_o),
        .rst_pin_oe_o(r_oe), .sda_i(sda), .scl_i(scl),
        .write_stop_i(write_stop), .sda_filt_o(), .scl_filt_o(),
        .reset_active_o(ra), .bus_enable_o(bus_en), .write_allow_o(wr_ok),
        .program_busy_o(busy));
    // same block built without watchdog, its reset pins left to the pulls
    supply_reset_watchdog_supervisor #(.POR_CYC(POR), .WDOG_CYC(WDOG),
        .PROG_CYC(PROG), .WATCHDOG_EN(1'b0)) dut_nowdog (
        .clk_i(clk_i), .rst_i(rst_i), .supply_ok_i(supply_ok),
        .write_prot_i(write_prot), .rst_n_pin_i(RST_N_PIN_IDLE),
        .rst_n_pin_o(), .rst_n_pin_oe_o(), .rst_pin_i(RST_PIN_IDLE),
        .rst_pin_o(), .rst_pin_oe_o(), .sda_i(sda), .scl_i(scl),
        .write_stop_i(write_stop), .sda_filt_o(), .scl_filt_o(),
        .reset_active_o(ra2), .bus_enable_o(), .write_allow_o(),
        .program_busy_o());
    host_net_model host (
        .rst_n_pin_o(rn_o), .rst_n_pin_oe_o(rn_oe), .rst_pin_o(r_o),
        .rst_pin_oe_o(r_oe), .push_low_i(push_low), .push_high_i(push_high),
        .frame_i(frame), .rst_n_lvl_o(rn_lvl), .rst_lvl_o(r_lvl),
        .sda_o(sda), .scl_o(scl));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask
    task automatic chk(input logic got, input logic exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // bounded wait on reset_active (sel 0) or program_busy (sel 1)
    task automatic wait_for(input int sel, input logic val, input int lim);
        n = 0;
        while ((sel ? busy : ra) !== val && n < lim) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= lim) begin
            fails++;
            $display("ERROR %0t wait limit reached", $time);
            end_sim();
        end
    endtask
    // short bus frame so the data line shows edges
    task automatic kick();
        frame = 1'b1;
        cyc(20);
        frame = 1'b0;
        cyc(10);
    endtask
    task automatic pulse_stop();
        write_stop = 1'b1;
        cyc(1);
        write_stop = 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_power_up();
        cyc(20);
        chk(rn_lvl, 1'b0, "low pin not driven in undervolt");
        chk(r_lvl, 1'b1, "high pin not driven in undervolt");
        chk(wr_ok, 1'b0, "writes allowed before power-up");
        supply_ok = 1'b1;
        wait_for(0, 1'b0, POR + 20);
        chk(logic'(n >= POR && n <= POR + 8), 1'b1, "power-up time");
        chk(rn_lvl & ~r_lvl & rn_oe, 1'b1, "pins not released");
        chk(bus_en & wr_ok, 1'b1, "bus not enabled after reset");
        cyc(POR);
        $display("power-up test done");
    endtask

    task automatic t_glitch();
        kick();
        push_low = 1'b1;
        cyc(2);
        push_low = 1'b0;
        push_high = 1'b1;
        cyc(2);
        push_high = 1'b0;
        cyc(15);
        chk(ra, 1'b0, "short pulse started reset");
        $display("glitch test done");
    endtask

    task automatic t_manual();
        for (int p = 0; p < 2; p++) begin
            kick();
            if (p == 0) push_low = 1'b1;
            else push_high = 1'b1;
            cyc(30);
            chk(ra, 1'b1, "forced level not held as reset");
            chk(bus_en, 1'b0, "bus enabled in forced reset");
            push_low = 1'b0;
            push_high = 1'b0;
            cyc(12);
            chk(rn_lvl, 1'b0, "no drive after release edge");
            wait_for(0, 1'b0, POR + 20);
            chk(logic'(n >= POR - 10 && n <= POR), 1'b1, "manual time");
        end
        $display("manual reset test done");
    endtask

    task automatic t_program();
        kick();
        pulse_stop();
        chk(busy, 1'b1, "program cycle not started");
        cyc(1);
        chk(bus_en | wr_ok, 1'b0, "bus on during program");
        wait_for(1, 1'b0, PROG + 5);
        chk(logic'(n == PROG - 1), 1'b1, "program length");
        cyc(2);
        chk(bus_en & wr_ok, 1'b1, "bus not back after program");
        write_prot = 1'b1;
        cyc(5);
        chk(wr_ok, 1'b0, "writes allowed when protected");
        pulse_stop();
        cyc(1);
        chk(busy, 1'b0, "program started when protected");
        write_prot = 1'b0;
        cyc(5);
        chk(wr_ok, 1'b1, "writes blocked after unprotect");
        $display("program test done");
    endtask

    task automatic t_brownout();
        kick();
        supply_ok = 1'b0;
        cyc(6);
        chk(~rn_lvl & r_lvl, 1'b1, "brownout reset missing");
        chk(wr_ok, 1'b0, "writes allowed in brownout");
        pulse_stop();
        cyc(1);
        chk(busy, 1'b0, "program in brownout");
        supply_ok = 1'b1;
        wait_for(0, 1'b0, POR + 20);
        chk(logic'(n >= POR && n <= POR + 8), 1'b1, "recovery time");
        $display("brownout test done");
    endtask

    task automatic t_watchdog();
        for (int i = 0; i < 6; i++) begin
            kick();
            cyc(120);
        end
        chk(ra, 1'b0, "watchdog fired despite activity");
        kick();
        wait_for(0, 1'b1, WDOG + 40);
        chk(logic'(n >= WDOG - 40 && n <= WDOG + 10), 1'b1, "wdog time");
        chk(ra2, 1'b0, "watchdog fired in build without it");
        wait_for(0, 1'b0, POR + 20);
        chk(logic'(n >= POR - 2 && n <= POR + 4), 1'b1, "wdog reset");
        cyc(WDOG - 10);
        chk(ra, 1'b0, "watchdog counted during reset");
        wait_for(0, 1'b1, 30);
        wait_for(0, 1'b0, POR + 20);
        $display("watchdog test done");
    endtask

    // ------------------------------------------------------------
    // clock and main sequence
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        {rst_i, supply_ok, write_prot, write_stop} = 4'b1000;
        {push_low, push_high, frame} = 3'b000;
        fails = 0;
        n_checks = 0;
        cyc(4);
        rst_i = 1'b0;
        t_power_up();
        t_glitch();
        t_manual();
        t_program();
        t_brownout();
        t_watchdog();
        end_sim();
    end
endmodule
`default_nettype wire
